// ==== verilog/hms_sequencer.sv ====
// Halt mode power sequencer with an APB register slave.
`default_nettype none

// Contract
// R1 - Halt enters active-halt when oscillator wake enable is 1, full halt when 0.
// R2 - Active-halt ends only on counter interrupt, specific wake interrupt or reset.
// R3 - Interrupt wake from active-halt skips the stabilization wait; CPU resumes at once.
// R4 - Active-halt exit inserts the stabilization delay only for reset wake-up.
// R5 - Entering either halt mode forces interrupt level bits to 10b.
// R6 - An interrupt already pending at halt entry wakes the device immediately.
// R7 - Active-halt keeps only oscillator and real-time counter clocked.
// R8 - Entering active-halt with watchdog active causes no watchdog reset.
// R9 - Clearing the wake enable during the post-wake delay gives full halt meanwhile.
// R10 - Full halt ends only on specific wake interrupts or reset, never the counter.
// R11 - Full halt exit restarts oscillator and waits 256 or 4096 cycles first.
// R12 - Full halt stops the oscillator, CPU and peripherals.
// R13 - Watchdog-in-halt option decides whether halt with watchdog enabled resets.
// R14 - Wake interrupt service pushes condition code, sets level, pop restores it.
// R15 - Opcode 8e is decoded as the halt instruction.
// R16 - Software should configure a wake-up pin and its sensitivity before halt.
// R17 - Wake pins and reset wake are sensed without the main oscillator.
module hms_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_opcode,
  input  wire logic [1:0]  isr_level,
  input  wire logic        cc_pop,
  input  wire logic        rtc_irq,
  input  wire logic        irq_pending,
  input  wire logic        ext_wake_pin,
  input  wire logic        wake_reset_pin,
  output logic      [1:0]  condition_code_reg,
  output logic             cc_push,
  output logic             cpu_resume,
  output logic             resume_from_reset,
  output logic             osc_enable,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             rtc_clk_en,
  output logic             watchdog_reset,
  output logic             watchdog_hold
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  hms_pkg::hms_state_t state;
  hms_pkg::hms_state_t next_state;
  logic [3:0]  main_clock_ctrl_status_reg;
  logic [1:0]  stacked_cc;
  logic [12:0] stab_cnt;
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic        halt_exec;
  logic        osc_wakeup_int_enable;
  logic        watchdog_in_halt_option;
  logic        wdg_enable;
  logic        stab_done;
  logic        ext_wake;
  logic        rst_wake;
  logic        act_wake_irq;
  logic        full_wake_irq;
  logic        irq_resume;
  logic        apb_wr;
  logic        apb_rd;

  // Low power states in which the CPU clock stays off.
  function automatic logic is_halted(input hms_pkg::hms_state_t s);
    is_halted = (s == hms_pkg::ST_ACT_HALT) || (s == hms_pkg::ST_FULL_HALT) ||
                (s == hms_pkg::ST_REM_HALT);
  endfunction

  // Stabilization length from the delay option, minus one for a zero-based count.
  function automatic logic [12:0] stab_last(input logic long_dly);
    stab_last = (long_dly ? hms_pkg::STAB_LONG_CYC : hms_pkg::STAB_SHORT_CYC) -
                hms_pkg::STAB_CNT_ONE;
  endfunction

  assign osc_wakeup_int_enable   = main_clock_ctrl_status_reg[hms_pkg::CTRL_OIE];
  assign watchdog_in_halt_option = main_clock_ctrl_status_reg[hms_pkg::CTRL_WDG_HALT];
  assign wdg_enable              = main_clock_ctrl_status_reg[hms_pkg::CTRL_WDG_EN];

  // ==========================================================================
  // Wake pin synchronisers
  // ==========================================================================
  // The sampling clock is the always-on reference, not the gated oscillator,
  // so the pins stay visible while the main oscillator is stopped.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= (gi == 0) ? ext_wake_pin : wake_reset_pin; // R17
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  assign ext_wake = pin_sync[0];
  assign rst_wake = pin_sync[1];

  // ==========================================================================
  // Decode and wake qualification
  // ==========================================================================
  assign halt_exec     = instr_valid && (instr_opcode == hms_pkg::HALT_OPCODE); // R15
  // The counter is stopped in full halt, so of the halt modes it wakes active-halt alone.
  assign act_wake_irq  = rtc_irq || ext_wake || irq_pending; // R2 R6
  assign full_wake_irq = ext_wake || irq_pending; // R10 R6
  assign stab_done     = (stab_cnt ==
                          stab_last(main_clock_ctrl_status_reg[hms_pkg::CTRL_LONG_DLY]));
  assign irq_resume    = (state == hms_pkg::ST_ACT_HALT) && !rst_wake && act_wake_irq;

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb begin
    next_state = state;
    case (state)
      hms_pkg::ST_RUN: begin
        if (halt_exec && osc_wakeup_int_enable) begin
          next_state = hms_pkg::ST_ACT_HALT; // R1
        end else if (halt_exec && !(wdg_enable && !watchdog_in_halt_option)) begin
          next_state = hms_pkg::ST_FULL_HALT; // R1 R13
        end
      end
      hms_pkg::ST_ACT_HALT: begin
        if (rst_wake) begin
          next_state = hms_pkg::ST_STABILIZE; // R4
        end else if (act_wake_irq) begin
          next_state = hms_pkg::ST_GUARD; // R3
        end
      end
      hms_pkg::ST_FULL_HALT: begin
        if (rst_wake || full_wake_irq) begin
          next_state = hms_pkg::ST_STABILIZE; // R11
        end
      end
      hms_pkg::ST_STABILIZE: begin
        if (stab_done) begin
          next_state = hms_pkg::ST_RUN; // R11
        end
      end
      hms_pkg::ST_GUARD: begin
        if (stab_done) begin
          next_state = hms_pkg::ST_RUN;
        end else if (!osc_wakeup_int_enable) begin
          next_state = hms_pkg::ST_REM_HALT; // R9
        end
      end
      hms_pkg::ST_REM_HALT: begin
        if (stab_done) begin
          next_state = hms_pkg::ST_RUN; // R9
        end
      end
      default: begin
        next_state = hms_pkg::ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= hms_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Delay counter; it restarts on entry to the stabilize and guard states and keeps running
  // through the remaining-halt state so the original window is honoured.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt <= hms_pkg::STAB_CNT_ZERO;
    end else if (next_state != state && (next_state == hms_pkg::ST_STABILIZE ||
                                         next_state == hms_pkg::ST_GUARD)) begin
      stab_cnt <= hms_pkg::STAB_CNT_ZERO;
    end else if (state == hms_pkg::ST_STABILIZE || state == hms_pkg::ST_GUARD ||
                 state == hms_pkg::ST_REM_HALT) begin
      stab_cnt <= stab_cnt + hms_pkg::STAB_CNT_ONE;
    end
  end

  // ==========================================================================
  // Wake result and watchdog
  // ==========================================================================
  // Resume pulses and the cause flag; the CPU samples the flag with the pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_resume        <= 1'b0;
      resume_from_reset <= 1'b0;
      cc_push           <= 1'b0;
    end else begin
      cpu_resume <= irq_resume || (state == hms_pkg::ST_STABILIZE && stab_done); // R3 R11
      cc_push    <= irq_resume; // R14
      if (state == hms_pkg::ST_ACT_HALT || state == hms_pkg::ST_FULL_HALT) begin
        resume_from_reset <= rst_wake; // R4
      end
      if (state == hms_pkg::ST_STABILIZE && stab_done && !resume_from_reset) begin
        cc_push <= 1'b1; // R14
      end
    end
  end

  // Full halt with the watchdog armed and the option cleared becomes a reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= (state == hms_pkg::ST_RUN) && halt_exec && !osc_wakeup_int_enable &&
                        wdg_enable && !watchdog_in_halt_option; // R13 R8
    end
  end

  // ==========================================================================
  // Clock gating
  // ==========================================================================
  // Oscillator runs everywhere but full halt and its remainder.
  always_comb begin
    osc_enable    = !(state == hms_pkg::ST_FULL_HALT || state == hms_pkg::ST_REM_HALT); // R12
    rtc_clk_en    = osc_enable; // R7
    cpu_clk_en    = !is_halted(state) && state != hms_pkg::ST_STABILIZE; // R7 R12
    periph_clk_en = cpu_clk_en; // R7
    watchdog_hold = is_halted(state); // R8
  end

  // ==========================================================================
  // Condition code interrupt level
  // ==========================================================================
  // Push saves the level in force before the service level replaces it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_code_reg <= hms_pkg::CC_ILEVEL_RESET;
      stacked_cc         <= hms_pkg::CC_ILEVEL_RESET;
    end else if (state == hms_pkg::ST_RUN && next_state != hms_pkg::ST_RUN) begin
      condition_code_reg <= hms_pkg::CC_ILEVEL_HALT; // R5
    end else if (cc_push) begin
      stacked_cc         <= condition_code_reg; // R14
      condition_code_reg <= isr_level; // R14
    end else if (cc_pop) begin
      condition_code_reg <= stacked_cc; // R14
    end else if (apb_wr && paddr == hms_pkg::CC_ADDR) begin
      condition_code_reg <= pwdata[1:0];
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Zero wait states; unmapped addresses answer with an error and read zero.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_clock_ctrl_status_reg <= hms_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == hms_pkg::CTRL_ADDR) begin
      main_clock_ctrl_status_reg <= pwdata[hms_pkg::CTRL_W-1:0]; // R1
    end
  end

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == hms_pkg::CTRL_ADDR) begin
      prdata[hms_pkg::CTRL_W-1:0] = main_clock_ctrl_status_reg;
    end else if (paddr == hms_pkg::STATUS_ADDR) begin
      prdata[hms_pkg::STAT_STATE_LSB +: 6] = state;
      prdata[hms_pkg::STAT_CC_LSB +: 2]    = condition_code_reg;
      prdata[hms_pkg::STAT_FROM_RST]       = resume_from_reset;
    end else if (paddr == hms_pkg::CC_ADDR) begin
      prdata[1:0] = condition_code_reg;
    end else begin
      pslverr = psel && penable;
    end
    if (!apb_rd) begin
      prdata = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_act_irq_wake;
    state == hms_pkg::ST_ACT_HALT && !rst_wake && act_wake_irq;
  endsequence

  sequence s_resume_now;
    state == hms_pkg::ST_GUARD && cpu_resume && cc_push;
  endsequence

  chk_halt_mode_sel: assert property (@(posedge pclk) disable iff (!presetn) // R1
    state == hms_pkg::ST_RUN && halt_exec && osc_wakeup_int_enable
    |=> state == hms_pkg::ST_ACT_HALT)
    else $error("halt with wake enable did not enter active-halt");

  chk_act_wake_fast: assert property (@(posedge pclk) disable iff (!presetn) // R3
    s_act_irq_wake |=> s_resume_now)
    else $error("interrupt wake from active-halt did not resume at once");

  chk_reset_wake_dly: assert property (@(posedge pclk) disable iff (!presetn) // R4
    state == hms_pkg::ST_ACT_HALT && rst_wake |=> state == hms_pkg::ST_STABILIZE ##0
    !cpu_resume [*8])
    else $error("reset wake skipped the stabilization delay");

  chk_cc_forced: assert property (@(posedge pclk) disable iff (!presetn) // R5
    state == hms_pkg::ST_RUN ##1 (state == hms_pkg::ST_ACT_HALT ||
    state == hms_pkg::ST_FULL_HALT) |-> condition_code_reg == hms_pkg::CC_ILEVEL_HALT)
    else $error("interrupt level not forced on halt entry");

  chk_act_clocks: assert property (@(posedge pclk) disable iff (!presetn) // R7
    state == hms_pkg::ST_ACT_HALT |-> osc_enable && rtc_clk_en && !cpu_clk_en &&
    !periph_clk_en)
    else $error("active-halt clock gating wrong");

  chk_wdg_act_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R8
    state == hms_pkg::ST_RUN && halt_exec && osc_wakeup_int_enable |=> !watchdog_reset)
    else $error("watchdog reset on active-halt entry");

  chk_rem_halt: assert property (@(posedge pclk) disable iff (!presetn) // R9
    state == hms_pkg::ST_GUARD && !stab_done && !osc_wakeup_int_enable
    |=> state == hms_pkg::ST_REM_HALT && !osc_enable)
    else $error("wake enable cleared early did not give full halt");

  chk_full_rtc_off: assert property (@(posedge pclk) disable iff (!presetn) // R10
    state == hms_pkg::ST_FULL_HALT && !rst_wake && !full_wake_irq
    |=> state == hms_pkg::ST_FULL_HALT)
    else $error("full halt left without a wake source");

  chk_stab_short: assert property (@(posedge pclk) disable iff (!presetn) // R11
    state == hms_pkg::ST_FULL_HALT && rst_wake &&
    !main_clock_ctrl_status_reg[hms_pkg::CTRL_LONG_DLY] &&
    (!apb_wr || paddr != hms_pkg::CTRL_ADDR) |=> state == hms_pkg::ST_STABILIZE ##256
    state == hms_pkg::ST_RUN && cpu_resume)
    else $error("short stabilization delay not 256 cycles");

  chk_full_osc_off: assert property (@(posedge pclk) disable iff (!presetn) // R12
    state == hms_pkg::ST_FULL_HALT |-> !osc_enable && !cpu_clk_en && !periph_clk_en)
    else $error("oscillator running in full halt");

  chk_wdg_option: assert property (@(posedge pclk) disable iff (!presetn) // R13
    state == hms_pkg::ST_RUN && halt_exec && !osc_wakeup_int_enable && wdg_enable &&
    !watchdog_in_halt_option |=> watchdog_reset && state == hms_pkg::ST_RUN)
    else $error("halt with watchdog armed did not reset");

  chk_cc_push_lvl: assert property (@(posedge pclk) disable iff (!presetn) // R14
    cc_push && !cc_pop && !(state == hms_pkg::ST_RUN && next_state != hms_pkg::ST_RUN)
    |=> condition_code_reg == $past(isr_level) && stacked_cc == $past(condition_code_reg))
    else $error("condition code not stacked on wake service");

endmodule

`default_nettype wire

// ==== verilog/hms_pkg.sv ====
// Constants and types shared by the halt mode power sequencer.
`default_nettype none

package hms_pkg;

  // ==========================================================================
  // Instruction decode and condition code values
  // ==========================================================================
  localparam logic [7:0]  HALT_OPCODE     = 8'h8e;
  localparam logic [1:0]  CC_ILEVEL_HALT  = 2'h2;
  localparam logic [1:0]  CC_ILEVEL_RESET = 2'h3;

  // ==========================================================================
  // Oscillator stabilization delays, in CPU cycles
  // ==========================================================================
  localparam logic [12:0] STAB_SHORT_CYC  = 13'h0100;
  localparam logic [12:0] STAB_LONG_CYC   = 13'h1000;
  localparam logic [12:0] STAB_CNT_ONE    = 13'h0001;
  localparam logic [12:0] STAB_CNT_ZERO   = 13'h0000;

  // ==========================================================================
  // Register map, byte addresses on the APB
  // ==========================================================================
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] CTRL_ADDR       = 12'h000;
  localparam logic [11:0] STATUS_ADDR     = 12'h004;
  localparam logic [11:0] CC_ADDR         = 12'h008;

  // Control register field positions and reset value.
  localparam int          CTRL_OIE        = 0;
  localparam int          CTRL_LONG_DLY   = 1;
  localparam int          CTRL_WDG_HALT   = 2;
  localparam int          CTRL_WDG_EN     = 3;
  localparam int          CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  // Status register field positions.
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_CC_LSB     = 8;
  localparam int          STAT_FROM_RST   = 10;

  // ==========================================================================
  // Sequencer states, one-hot
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_RUN       = 6'h01,
    ST_ACT_HALT  = 6'h02,
    ST_FULL_HALT = 6'h04,
    ST_STABILIZE = 6'h08,
    ST_GUARD     = 6'h10,
    ST_REM_HALT  = 6'h20
  } hms_state_t;

endpackage

`default_nettype wire

// ==== tb/hms_cpu_model.sv ====
// Behavioural model of the CPU core that services wake-up interrupts.
`default_nettype none

module hms_cpu_model #(
  parameter logic [1:0] ISR_LVL = 2'h1,
  parameter int         POP_DLY = 4
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cc_push,
  output logic      [1:0] isr_level,
  output logic            cc_pop
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt;

  // ==========================================================================
  // Interrupt service
  // ==========================================================================
  // The level is only valid with the push; otherwise it shows the inverse so a
  // design sampling at the wrong moment picks up a wrong value.
  assign isr_level = cc_push ? ISR_LVL : ~ISR_LVL;

  // The routine returns a fixed time after entry and pops the saved level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= 0;
      cc_pop <= 1'b0;
    end else begin
      cnt    <= cc_push ? POP_DLY : ((cnt != 0) ? cnt - 1 : 0);
      cc_pop <= (cnt == 1);
    end
  end

endmodule

`default_nettype wire

// ==== tb/tb_halt_mode_power_sequencer.sv ====
// Self-checking bench for the halt mode power sequencer.
`default_nettype none

module tb_halt_mode_power_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [1:0] ISR_LVL = 2'h1;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        instr_valid = 1'b0;
  logic [7:0]  instr_opcode = 8'h00;
  logic        rtc_irq = 1'b0;
  logic        irq_pending = 1'b0;
  logic        ext_wake_pin = 1'b0;
  logic        wake_reset_pin = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, cc_push, cc_pop, cpu_resume, resume_from_reset;
  logic        osc_enable, cpu_clk_en, periph_clk_en, rtc_clk_en;
  logic        watchdog_reset, watchdog_hold;
  logic [1:0]  isr_level, condition_code_reg;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;
  int          rs_cnt = 0;
  int          wd_cnt = 0;
  int          n;
  logic [31:0] rd;
  logic        err, got_push, got_rst;

  hms_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .isr_level(isr_level), .cc_pop(cc_pop), .rtc_irq(rtc_irq), .irq_pending(irq_pending),
    .ext_wake_pin(ext_wake_pin), .wake_reset_pin(wake_reset_pin),
    .condition_code_reg(condition_code_reg), .cc_push(cc_push), .cpu_resume(cpu_resume),
    .resume_from_reset(resume_from_reset), .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en),
    .watchdog_reset(watchdog_reset), .watchdog_hold(watchdog_hold));

  hms_cpu_model #(.ISR_LVL(ISR_LVL), .POP_DLY(4)) cpu_u (.pclk(pclk), .presetn(presetn),
    .cc_push(cc_push), .isr_level(isr_level), .cc_pop(cc_pop));

  // ==========================================================================
  // Clock, event counters and hang guard
  // ==========================================================================
  initial begin
    forever #20 pclk = ~pclk;
  end

  // Pulses are counted so that a short pulse between two samples is not lost.
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cpu_resume === 1'b1) rs_cnt++;
    if (watchdog_reset === 1'b1) wd_cnt++;
    if (cyc_cnt == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h", $time, msg, got);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && cyc_cnt < 20000);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic halt(input logic [7:0] op);
    @(posedge pclk);
    instr_valid  <= 1'b1;
    instr_opcode <= op;
    @(posedge pclk);
    instr_valid  <= 1'b0;
    cyc(3);
  endtask

  // Control word, then interrupt level 0 so the forced level is visible.
  task automatic prep(input logic [31:0] ctrl);
    apb(1'b1, hms_pkg::CTRL_ADDR, ctrl);
    apb(1'b1, hms_pkg::CC_ADDR, 32'h0);
  endtask

  task automatic wake_wait(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (cpu_resume !== 1'b1 && n < lim);
    got_push = cc_push;
    got_rst  = resume_from_reset;
  endtask

  task automatic rtc_wake();
    @(posedge pclk);
    rtc_irq <= 1'b1;
    wake_wait(8);
    @(posedge pclk);
    rtc_irq <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    chk_bit(osc_enable & cpu_clk_en & periph_clk_en & rtc_clk_en, 1'b1, "clocks at reset");
    apb(1'b0, hms_pkg::STATUS_ADDR, 32'h0);
    chk_word(rd, 32'h0000_0301, "status reset");
    apb(1'b1, hms_pkg::STATUS_ADDR, 32'hffff_ffff);
    apb(1'b0, hms_pkg::STATUS_ADDR, 32'h0);
    chk_word(rd, 32'h0000_0301, "status read-only");
    apb(1'b0, 12'h00c, 32'h0);
    chk_word({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, hms_pkg::CTRL_ADDR, 32'hffff_ffff);
    apb(1'b0, hms_pkg::CTRL_ADDR, 32'h0);
    chk_word(rd, 32'h0000_000f, "ctrl width");
  endtask

  task automatic t_active();
    prep(32'h1);
    halt(hms_pkg::HALT_OPCODE);
    chk_word({30'h0, condition_code_reg}, 32'h2, "level forced");
    chk_bit(cpu_clk_en | periph_clk_en, 1'b0, "cpu clock in active-halt");
    chk_bit(osc_enable & rtc_clk_en, 1'b1, "counter clock in active-halt");
    rtc_wake();
    chk_bit(n <= 2, 1'b1, "wake without delay");
    chk_bit(got_push & ~got_rst, 1'b1, "interrupt service");
    cyc(1);
    chk_word({30'h0, condition_code_reg}, {30'h0, ISR_LVL}, "isr level");
    cyc(8);
    chk_word({30'h0, condition_code_reg}, 32'h2, "level restored");
    cyc(300);
    chk_bit(cpu_clk_en, 1'b1, "back to run");
  endtask

  task automatic t_rem();
    prep(32'h1);
    halt(hms_pkg::HALT_OPCODE);
    rtc_wake();
    apb(1'b1, hms_pkg::CTRL_ADDR, 32'h0);
    cyc(2);
    chk_bit(osc_enable, 1'b0, "halt for rest of delay");
    cyc(300);
    chk_bit(osc_enable & cpu_clk_en, 1'b1, "run after delay");
  endtask

  task automatic t_full();
    int w0;
    int r0;
    w0 = wd_cnt;
    prep(32'hc);
    halt(hms_pkg::HALT_OPCODE);
    chk_word({30'h0, condition_code_reg}, 32'h2, "level forced");
    chk_bit(osc_enable | cpu_clk_en | periph_clk_en, 1'b0, "full halt clocks");
    chk_word(wd_cnt, w0, "halt allowed by option");
    r0 = rs_cnt;
    @(posedge pclk);
    rtc_irq <= 1'b1;
    cyc(6);
    chk_word(rs_cnt, r0, "counter cannot wake");
    @(posedge pclk);
    rtc_irq      <= 1'b0;
    ext_wake_pin <= 1'b1;
    wake_wait(300);
    @(posedge pclk);
    ext_wake_pin <= 1'b0;
    chk_bit(n >= 256 && n <= 264, 1'b1, "short stabilization");
    chk_bit(got_push & ~got_rst, 1'b1, "interrupt after delay");
    cyc(10);
  endtask

  task automatic t_rst(input logic [31:0] ctrl, input int lo, input int hi);
    prep(ctrl);
    halt(hms_pkg::HALT_OPCODE);
    @(posedge pclk);
    wake_reset_pin <= 1'b1;
    wake_wait(4300);
    @(posedge pclk);
    wake_reset_pin <= 1'b0;
    chk_bit(n >= lo && n <= hi, 1'b1, "reset wake delay");
    chk_bit(~got_push & got_rst, 1'b1, "reset vector");
    cyc(5);
  endtask

  task automatic t_pend();
    int r0;
    prep(32'h1);
    @(posedge pclk);
    irq_pending <= 1'b1;
    r0 = rs_cnt;
    halt(hms_pkg::HALT_OPCODE);
    cyc(3);
    chk_word(rs_cnt, r0 + 1, "pending wakes at once");
    @(posedge pclk);
    irq_pending <= 1'b0;
    cyc(300);
  endtask

  task automatic t_wdg();
    int w0;
    w0 = wd_cnt;
    prep(32'h8);
    halt(hms_pkg::HALT_OPCODE);
    chk_word(wd_cnt, w0 + 1, "halt gives watchdog reset");
    chk_bit(cpu_clk_en, 1'b1, "no halt entered");
    prep(32'h9);
    halt(hms_pkg::HALT_OPCODE);
    chk_word(wd_cnt, w0 + 1, "active-halt no reset");
    chk_bit(~cpu_clk_en & watchdog_hold, 1'b1, "active-halt entered");
    rtc_wake();
    chk_bit(got_push, 1'b1, "counter wakes");
    cyc(300);
  endtask

  task automatic t_opc();
    prep(32'h1);
    halt(8'h8f);
    chk_bit(cpu_clk_en, 1'b1, "other opcode ignored");
    apb(1'b0, hms_pkg::STATUS_ADDR, 32'h0);
    chk_word({26'h0, rd[5:0]}, 32'h1, "still running");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    t_regs();
    t_active();
    t_rem();
    t_full();
    t_rst(32'h1, 256, 264);
    t_rst(32'h2, 4096, 4104);
    t_pend();
    t_wdg();
    t_opc();
    test_done();
  end

endmodule

`default_nettype wire
